// *** hw/fsts_pkg.sv ***
// Constants, types and helper functions shared by the sector transfer sequencer
package fsts_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses on the Wishbone slave)
  // ------------------------------------------------------------
  localparam logic [7:0] FSTS_ADR_CTRL = 8'h00;   // Command launch word
  localparam logic [7:0] FSTS_ADR_ID = 8'h04;     // Commanded cylinder, head, sector, size
  localparam logic [7:0] FSTS_ADR_LIMIT = 8'h08;  // Last sector and short-sector length
  localparam logic [7:0] FSTS_ADR_DATA = 8'h0C;   // Byte window towards the host
  localparam logic [7:0] FSTS_ADR_STATUS = 8'h10; // Progress and result status
  localparam logic [7:0] FSTS_ADR_RESULT = 8'h14; // Sector address for the result phase

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;    // Write one to launch a command
  localparam int CTRL_CMD_LSB = 1;      // Three-bit command code
  localparam int CTRL_MT_BIT = 4;       // Continue onto side 1
  localparam int CTRL_SK_BIT = 5;       // Skip sectors of the unwanted mark type
  localparam int STS_BUSY_BIT = 24;     // Command executing
  localparam int STS_FULL_BIT = 25;     // Data window holds a byte
  localparam int ST0_IC_LSB = 6;        // Two-bit interrupt code in status_zero
  localparam int ST1_DE_BIT = 5;        // CRC error
  localparam int ST1_OR_BIT = 4;        // Overrun or underrun
  localparam int ST1_ND_BIT = 2;        // Sector not found or ID mismatch
  localparam int ST1_MA_BIT = 0;        // No ID address mark
  localparam int ST2_CM_BIT = 6;        // Unwanted data mark met
  localparam int ST2_DD_BIT = 5;        // CRC error in the data field

  // ------------------------------------------------------------
  // Encodings and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_READ_DEL = 3'h1;
  localparam logic [2:0] CMD_READ_TRACK = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_WRITE_DEL = 3'h4;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [7:0] FIRST_SECTOR = 8'h01;
  localparam logic [14:0] BASE_SECTOR_BYTES = 15'h0080;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [1:0] INDEX_LIMIT = 2'h2;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int HEAD_LOAD_NS = 16000000;  // Head load settle time
  localparam int HEAD_LOAD_CYC = (HEAD_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    FSTS_IDLE, FSTS_HEADLOAD, FSTS_TRK_WAIT, FSTS_SEEK_ID, FSTS_WAIT_MARK,
    FSTS_RD_DATA, FSTS_WR_MARK, FSTS_WR_DATA, FSTS_WR_CRC, FSTS_DONE
  } fsts_state_e;

  typedef struct packed {
    logic [7:0] c;  // Cylinder
    logic [7:0] h;  // Head
    logic [7:0] r;  // Sector number
    logic [7:0] n;  // Size code
  } fsts_chrn_s;

  // One CRC-16 step over a whole byte
  function automatic logic [15:0] fsts_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : fsts_crc_byte

endpackage : fsts_pkg

// *** hw/fsts_sequencer.sv ***
// Execution-phase sequencer for floppy sector read and write commands
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Multi-track continues from side 0 onto side 1
// - Without multi-track stop at last sector of side
// - Normal read: deleted mark flagged, skipped with SK, else read then stop
// - Deleted read: mark roles swapped, skip or stop
// - Deleted read targets sectors with deleted mark
// - Sector address advances after each sector
// - Track read starts at index, ignores numbering
// - Track read keeps going over CRC errors
// - Track read flags ID mismatch as no data
// - Track read ends after end_sector_limit sectors
// - Track read: no ID by second index aborts
// - Below limit: result sector plus one
// - At limit: sector one, cylinder/head per table
// - Write loads head, matches ID, takes host data
// - Write appends computed CRC after each field
// - Write advances sector and continues
// - Write pads field with zeros after terminate
// - Write ID CRC error aborts with data error
// - Deleted write emits deleted data mark
// - Size code zero: data_length bytes, full sector
// - Sector not found by second index aborts
// - Read terminate: stop passing, finish sector
module fsts_sequencer
  import fsts_pkg::*;
#(
  parameter int HEAD_LOAD_CYCLES = HEAD_LOAD_CYC  // Head settle wait, shorten for simulation
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Host side terminal count
  input wire logic transfer_terminate_in,
  // Drive side, read channel
  input wire logic index_pulse_in,
  input wire logic disk_id_valid_in,
  input wire fsts_chrn_s disk_id_in,
  input wire logic disk_id_crc_ok_in,
  input wire logic disk_mark_valid_in,
  input wire logic disk_mark_deleted_in,
  input wire logic disk_byte_valid_in,
  input wire logic [7:0] disk_byte_in,
  input wire logic disk_crc_valid_in,
  input wire logic disk_crc_ok_in,
  // Drive side, write channel
  input wire logic disk_wr_req_in,
  output logic disk_wr_mark_out,
  output logic disk_wr_mark_deleted_out,
  output logic disk_wr_strobe_out,
  output logic [7:0] disk_wr_byte_out,
  output logic head_load_out,
  output logic busy_out
);

  // ------------------------------------------------------------
  // State record
  // ------------------------------------------------------------
  typedef struct packed {
    fsts_state_e st;          // Sequencer phase
    logic [2:0] cmd;          // Command in progress
    logic mt;                 // multi_track
    logic sk;                 // bypass_select
    fsts_chrn_s cmd_id;       // Commanded sector address as written by software
    fsts_chrn_s id;           // Working sector address
    logic [7:0] end_sector_limit;          // end_sector_limit
    logic [7:0] data_length;          // data_length
    logic [14:0] byte_cnt;    // Bytes of the current field handled
    logic [7:0] sect_cnt;     // Sectors done in a track read
    logic [1:0] idx_cnt;      // Index pulses while searching
    logic seen_id;            // An ID mark was seen since the command started
    logic stop;               // Host data flow halted
    logic last;               // Finish after the current sector
    logic skip;               // Current sector is passed over unread
    logic [7:0] hold;         // Data window byte
    logic hold_full;          // Data window occupied
    logic [15:0] crc;         // Running CRC for writes
    logic crc_lo;             // Second CRC byte pending
    logic [1:0] ic;           // interrupt_code
    logic nd;                 // no_data_flag
    logic ma;                 // absent_id_flag
    logic de;                 // data_error_flag
    logic dd;                 // Data field CRC error
    logic orun;               // Overrun or underrun seen
    logic cm;                 // control_mark_flag
    logic head_loaded;        // Head stays loaded after a command
    logic [23:0] hl_cnt;      // Head settle counter
    logic ack;                // Wishbone acknowledge
    logic [31:0] rdat;        // Wishbone read data
    logic wr_mark;            // Data mark request to the drive
    logic wr_mark_del;        // Mark is the deleted type
    logic wr_strobe;          // Byte presented to the drive
    logic [7:0] wr_byte;      // Byte towards the drive
  } fsts_state_s;

  fsts_state_s s_r;    // Registered state
  fsts_state_s s_nxt;  // Next state

  // ------------------------------------------------------------
  // Decoded helpers
  // ------------------------------------------------------------
  logic is_write;                  // Write or deleted write
  logic is_track;                  // Whole-track read
  logic [14:0] sect_bytes;         // Bytes in one sector
  logic [14:0] xfer_bytes;         // Bytes exchanged with the host
  logic wb_req;                    // New bus request this cycle
  logic id_match;                  // Drive ID equals working address
  logic at_eot;                    // Working sector is the last one
  logic [7:0] st0;                 // status_zero
  logic [7:0] st1;                 // status_one
  logic [7:0] st2;                 // status_two

  assign is_write = (s_r.cmd == CMD_WRITE) || (s_r.cmd == CMD_WRITE_DEL);
  assign is_track = (s_r.cmd == CMD_READ_TRACK);
  assign sect_bytes = BASE_SECTOR_BYTES << s_r.id.n[2:0];
  // Short sectors move only data_length bytes, the rest is still handled
  assign xfer_bytes = (s_r.id.n == 8'h00 && {7'h00, s_r.data_length} < BASE_SECTOR_BYTES) ? {7'h00, s_r.data_length} : sect_bytes;
  assign wb_req = wb_cyc_in && wb_stb_in && !s_r.ack;
  assign id_match = (disk_id_in == s_r.id);
  assign at_eot = (s_r.id.r == s_r.end_sector_limit);
  assign st0 = {s_r.ic, 6'h00};
  assign st1 = 8'((s_r.de << ST1_DE_BIT) | (s_r.orun << ST1_OR_BIT) | (s_r.nd << ST1_ND_BIT) | (s_r.ma << ST1_MA_BIT));
  assign st2 = 8'((s_r.cm << ST2_CM_BIT) | (s_r.dd << ST2_DD_BIT));

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // All behaviour lives here; the sector-end step decides between continuing and finishing
  always_comb begin
    logic hit_unwanted;
    logic next_byte_needed;
    hit_unwanted = 1'b0;
    next_byte_needed = 1'b0;
    s_nxt = s_r;
    s_nxt.wr_mark = 1'b0;
    s_nxt.wr_strobe = 1'b0;
    s_nxt.ack = 1'b0;

    // Bus slave: one wait-free answer, ack drops the cycle after
    if (wb_req) begin
      s_nxt.ack = 1'b1;
      s_nxt.rdat = 32'h0000_0000;
      if (wb_we_in) begin
        case (wb_adr_in)
          FSTS_ADR_CTRL: begin
            // Launch only from idle; a launch while busy is ignored
            if (wb_sel_in[0] && wb_dat_in[CTRL_START_BIT] && s_r.st == FSTS_IDLE) begin
              s_nxt.cmd = wb_dat_in[CTRL_CMD_LSB +: 3];
              s_nxt.mt = wb_dat_in[CTRL_MT_BIT];
              s_nxt.sk = wb_dat_in[CTRL_SK_BIT];
              s_nxt.id = s_r.cmd_id;
              s_nxt.ic = IC_NORMAL;
              {s_nxt.nd, s_nxt.ma, s_nxt.de, s_nxt.dd, s_nxt.orun, s_nxt.cm} = 6'h00;
              {s_nxt.stop, s_nxt.last, s_nxt.skip, s_nxt.seen_id} = 4'h0;
              s_nxt.idx_cnt = 2'h0;
              s_nxt.sect_cnt = 8'h00;
              s_nxt.hold_full = 1'b0;
              s_nxt.hl_cnt = 24'h00_0000;
              s_nxt.st = s_r.head_loaded ? FSTS_TRK_WAIT : FSTS_HEADLOAD;
            end
          end
          FSTS_ADR_ID: begin
            for (int b = 0; b < 4; b++) begin
              if (wb_sel_in[b]) begin
                s_nxt.cmd_id[b*8 +: 8] = wb_dat_in[b*8 +: 8];
              end
            end
          end
          FSTS_ADR_LIMIT: begin
            if (wb_sel_in[0]) begin
              s_nxt.end_sector_limit = wb_dat_in[7:0];
            end
            if (wb_sel_in[1]) begin
              s_nxt.data_length = wb_dat_in[15:8];
            end
          end
          FSTS_ADR_DATA: begin
            // Host supplies write data; a write while full is dropped
            if (wb_sel_in[0] && !s_r.hold_full) begin
              s_nxt.hold = wb_dat_in[7:0];
              s_nxt.hold_full = 1'b1;
            end
          end
          default: begin
            // Unmapped or read-only: acknowledged, no effect
          end
        endcase
      end else begin
        case (wb_adr_in)
          FSTS_ADR_CTRL: s_nxt.rdat = {26'h000_0000, s_r.sk, s_r.mt, s_r.cmd, 1'b0};
          FSTS_ADR_ID: s_nxt.rdat = s_r.cmd_id;
          FSTS_ADR_LIMIT: s_nxt.rdat = {16'h0000, s_r.data_length, s_r.end_sector_limit};
          FSTS_ADR_DATA: begin
            // Reading the window frees it for the next disk byte
            s_nxt.rdat = {24'h00_0000, s_r.hold};
            s_nxt.hold_full = 1'b0;
          end
          FSTS_ADR_STATUS: begin
            s_nxt.rdat = {8'h00, st0, st1, st2};
            s_nxt.rdat[STS_BUSY_BIT] = (s_r.st != FSTS_IDLE);
            s_nxt.rdat[STS_FULL_BIT] = s_r.hold_full;
          end
          FSTS_ADR_RESULT: s_nxt.rdat = s_r.id;
          default: s_nxt.rdat = 32'h0000_0000;
        endcase
      end
    end

    // Terminal count halts host traffic for the rest of the command
    if (transfer_terminate_in && s_r.st != FSTS_IDLE) begin
      s_nxt.stop = 1'b1;
      s_nxt.last = 1'b1;
    end

    case (s_r.st)
      FSTS_IDLE: begin
      end
      FSTS_HEADLOAD: begin
        // Wait the settle time before looking at the disk
        s_nxt.hl_cnt = s_r.hl_cnt + 24'h00_0001;
        if (s_r.hl_cnt >= 24'(HEAD_LOAD_CYCLES - 1)) begin
          s_nxt.head_loaded = 1'b1;
          s_nxt.st = FSTS_TRK_WAIT;
        end
      end
      FSTS_TRK_WAIT: begin
        // Only the track read waits for the index hole
        if (!is_track || index_pulse_in) begin
          s_nxt.st = FSTS_SEEK_ID;
        end
      end
      FSTS_SEEK_ID: begin
        if (index_pulse_in) begin
          s_nxt.idx_cnt = s_r.idx_cnt + 2'h1;
        end
        if (index_pulse_in && s_r.idx_cnt == INDEX_LIMIT - 2'h1) begin
          s_nxt.ic = IC_ABNORMAL;
          if (is_track && !s_r.seen_id) begin
            s_nxt.ma = 1'b1;
          end else begin
            s_nxt.nd = 1'b1;
          end
          s_nxt.st = FSTS_DONE;
        end else if (disk_id_valid_in) begin
          s_nxt.seen_id = 1'b1;
          if (is_track) begin
            // Every sector is taken regardless of numbering
            if (!id_match) begin
              s_nxt.nd = 1'b1;
            end
            if (!disk_id_crc_ok_in) begin
              s_nxt.de = 1'b1;
            end
            s_nxt.idx_cnt = 2'h0;
            s_nxt.st = FSTS_WAIT_MARK;
          end else if (id_match) begin
            s_nxt.idx_cnt = 2'h0;
            if (!disk_id_crc_ok_in) begin
              s_nxt.ic = IC_ABNORMAL;
              s_nxt.de = 1'b1;
              s_nxt.st = FSTS_DONE;
            end else if (is_write) begin
              s_nxt.st = FSTS_WR_MARK;
            end else begin
              s_nxt.st = FSTS_WAIT_MARK;
            end
          end
        end
      end
      FSTS_WAIT_MARK: begin
        if (disk_mark_valid_in) begin
          s_nxt.byte_cnt = 15'h0000;
          s_nxt.skip = 1'b0;
          // The wanted mark is normal for a read, deleted for a deleted read
          hit_unwanted = !is_track && (disk_mark_deleted_in ^ (s_r.cmd == CMD_READ_DEL));
          if (hit_unwanted) begin
            s_nxt.cm = 1'b1;
            if (s_r.sk) begin
              s_nxt.skip = 1'b1;  // Pass over unread
            end else begin
              s_nxt.last = 1'b1;  // Read it, then stop without advancing
            end
          end
          s_nxt.st = FSTS_RD_DATA;
        end
      end
      FSTS_RD_DATA: begin
        if (disk_byte_valid_in) begin
          s_nxt.byte_cnt = s_r.byte_cnt + 15'h0001;
          // Pass bytes only while host flow is open and within xfer_bytes (data_length for short sectors)
          if (!s_r.skip && !s_r.stop && s_r.byte_cnt < xfer_bytes) begin
            if (s_r.hold_full && !(wb_req && !wb_we_in && wb_adr_in == FSTS_ADR_DATA)) begin
              s_nxt.orun = 1'b1;  // Overrun acts as terminal count
              s_nxt.stop = 1'b1;
              s_nxt.last = 1'b1;
            end else begin
              s_nxt.hold = disk_byte_in;
              s_nxt.hold_full = 1'b1;
            end
          end
        end
        // Sector ends at its CRC check even after terminate
        if (disk_crc_valid_in) begin
          if (!disk_crc_ok_in && !s_r.skip) begin
            s_nxt.de = 1'b1;
            s_nxt.dd = 1'b1;
            if (!is_track) begin
              s_nxt.ic = IC_ABNORMAL;
              s_nxt.last = 1'b1;
              s_nxt.st = FSTS_DONE;
            end
          end
          if (is_track) begin
            s_nxt.sect_cnt = s_r.sect_cnt + 8'h01;
            s_nxt.id.r = s_r.id.r + 8'h01;
            // Count of sectors, not sector numbers, ends a track read
            if (s_r.sect_cnt + 8'h01 >= s_r.end_sector_limit || s_nxt.last) begin
              s_nxt.ic = (s_r.de || s_nxt.de || s_r.nd) ? IC_ABNORMAL : s_nxt.ic;
              s_nxt.st = FSTS_DONE;
            end else begin
              s_nxt.st = FSTS_SEEK_ID;
            end
          end else if (s_nxt.st != FSTS_DONE) begin
            if (s_r.last && !s_r.stop && s_r.cm && !s_r.skip) begin
              s_nxt.st = FSTS_DONE;  // Unwanted mark read: address held
            end else begin
              s_nxt.st = FSTS_SEEK_ID;
            end
          end
        end
      end
      FSTS_WR_MARK: begin
        s_nxt.wr_mark = 1'b1;
        s_nxt.wr_mark_del = (s_r.cmd == CMD_WRITE_DEL);
        s_nxt.byte_cnt = 15'h0000;
        s_nxt.crc = CRC_INIT;
        s_nxt.crc_lo = 1'b0;
        s_nxt.st = FSTS_WR_DATA;
      end
      FSTS_WR_DATA: begin
        if (disk_wr_req_in) begin
          // Host data while flowing, zeros after terminate or past xfer_bytes
          next_byte_needed = !s_r.stop && s_r.byte_cnt < xfer_bytes;
          s_nxt.wr_byte = 8'h00;
          if (next_byte_needed) begin
            if (s_r.hold_full) begin
              s_nxt.wr_byte = s_r.hold;
              s_nxt.hold_full = 1'b0;
            end else begin
              s_nxt.orun = 1'b1;  // Underrun pads like terminal count
              s_nxt.stop = 1'b1;
              s_nxt.last = 1'b1;
            end
          end
          s_nxt.wr_strobe = 1'b1;
          s_nxt.crc = fsts_crc_byte(s_r.crc, s_nxt.wr_byte);
          s_nxt.byte_cnt = s_r.byte_cnt + 15'h0001;
          if (s_r.byte_cnt == sect_bytes - 15'h0001) begin
            s_nxt.st = FSTS_WR_CRC;
          end
        end
      end
      FSTS_WR_CRC: begin
        // Close the field with the computed CRC, high byte first
        if (disk_wr_req_in) begin
          s_nxt.wr_strobe = 1'b1;
          s_nxt.wr_byte = s_r.crc_lo ? s_r.crc[7:0] : s_r.crc[15:8];
          s_nxt.crc_lo = 1'b1;
          if (s_r.crc_lo) begin
            s_nxt.st = FSTS_SEEK_ID;  // Continue with the next sector
          end
        end
      end
      FSTS_DONE: begin
        s_nxt.st = FSTS_IDLE;
      end
      default: s_nxt.st = FSTS_IDLE;
    endcase

    // Sector-end address step for reads and writes (not track reads)
    if (!is_track && s_r.st != FSTS_DONE && s_nxt.st == FSTS_SEEK_ID &&
        (s_r.st == FSTS_RD_DATA || s_r.st == FSTS_WR_CRC)) begin
      if (!at_eot) begin
        s_nxt.id.r = s_r.id.r + 8'h01;
        if (s_r.last) begin
          s_nxt.st = FSTS_DONE;
        end
      end else begin
        s_nxt.id.r = FIRST_SECTOR;
        if (s_r.mt) begin
          s_nxt.id.h = {s_r.id.h[7:1], ~s_r.id.h[0]};
        end
        if (!s_r.mt || s_r.id.h[0]) begin
          s_nxt.id.c = s_r.id.c + 8'h01;
          s_nxt.st = FSTS_DONE;  // Last sector of the last side
        end else if (s_r.last) begin
          s_nxt.st = FSTS_DONE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Synchronous reset; everything settles to idle with flags clear
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
      s_r.st <= FSTS_IDLE;
      s_r.end_sector_limit <= FIRST_SECTOR;
      s_r.crc <= CRC_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign wb_dat_out = s_r.rdat;
  assign wb_ack_out = s_r.ack;
  assign disk_wr_mark_out = s_r.wr_mark;
  assign disk_wr_mark_deleted_out = s_r.wr_mark_del;
  assign disk_wr_strobe_out = s_r.wr_strobe;
  assign disk_wr_byte_out = s_r.wr_byte;
  assign head_load_out = s_r.head_loaded;
  assign busy_out = (s_r.st != FSTS_IDLE);

endmodule : fsts_sequencer

`default_nettype wire

// *** tb/fsts_chk_sva.sv ***
// Port-level checker for the sector transfer sequencer
`timescale 1ns/10ps
`default_nettype none
module fsts_chk (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic disk_wr_req_in,
  input wire logic disk_wr_strobe_out,
  input wire logic disk_wr_mark_out,
  input wire logic head_load_out,
  input wire logic busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Mark is a single-cycle pulse
  sequence s_mark_ends; ##1 !disk_wr_mark_out; endsequence
  property p_ack; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  property p_strobe_req; disk_wr_strobe_out |-> $past(disk_wr_req_in); endproperty
  property p_strobe_busy; disk_wr_strobe_out |-> busy_out; endproperty
  property p_head_hold; head_load_out |=> head_load_out; endproperty
  property p_head_rise; $rose(head_load_out) |-> busy_out; endproperty
  property p_mark_head; disk_wr_mark_out |-> head_load_out && busy_out; endproperty
  property p_mark_pulse; disk_wr_mark_out |-> s_mark_ends; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_strobe_req: assert property (p_strobe_req) else $error("strobe without request");
  a_strobe_busy: assert property (p_strobe_busy) else $error("strobe while idle");
  a_head_hold: assert property (p_head_hold) else $error("head unloaded");
  a_head_rise: assert property (p_head_rise) else $error("head load while idle");
  a_mark_head: assert property (p_mark_head) else $error("mark before head load");
  a_mark_pulse: assert property (p_mark_pulse) else $error("mark too long");
endmodule : fsts_chk
bind fsts_sequencer fsts_chk u_chk (.*);
`default_nettype wire

// *** tb/fsts_drive.sv ***
// Drive model: one-sector track with index hole, ID field and write byte clock
`timescale 1ns/10ps
`default_nettype none
module fsts_drive
  import fsts_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic id_en_in,
  input wire fsts_chrn_s id_in,
  output logic index_out,
  output logic id_valid_out,
  output fsts_chrn_s id_out,
  output logic wr_req_out
);
  logic [9:0] pos_r; // Angle on the track, one turn per 1024 cycles
  // Everything keyed to the angle so timing repeats each turn
  always_ff @(posedge clk_in) begin
    pos_r <= rst_b_in ? pos_r + 10'h001 : 10'h000;
    index_out <= rst_b_in && pos_r == 10'h3FF;
    id_valid_out <= id_en_in && pos_r == 10'h013; // Sole ID field
    id_out <= (pos_r == 10'h013) ? id_in : ~id_in; // Field not held outside its pulse
    wr_req_out <= pos_r[1:0] == 2'b11; // Byte clock of the write head
  end
endmodule : fsts_drive
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the sector transfer sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fsts_pkg::*;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, term = 0, id_en = 1, crc_ok = 1, mdel_seen = 0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00, wbyte;
  logic [31:0] dat = 32'h0000_0000, rdat;
  logic [63:0] e;
  logic ack, mrk, mdel, wstb, idx, idv, req, hl, busy;
  logic [15:0] lfsr = 16'h0002, crc_x = 16'hFFFF;
  fsts_chrn_s id_set = '0, disk_set = '0, id_drv;
  logic [63:0] q[$];
  int miscompares = 0, comparisons = 0, cycles = 0, wr_cnt = 0, nz = 0;
  always #25 clk = ~clk;
  fsts_sequencer #(.HEAD_LOAD_CYCLES(4)) dut (.sys_clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .transfer_terminate_in(term), .index_pulse_in(idx), .disk_id_valid_in(idv),
    .disk_id_in(id_drv), .disk_id_crc_ok_in(crc_ok), .disk_mark_valid_in(1'b0), .disk_mark_deleted_in(1'b0),
    .disk_byte_valid_in(1'b0), .disk_byte_in(lfsr[15:8]), .disk_crc_valid_in(1'b0), .disk_crc_ok_in(crc_ok),
    .disk_wr_req_in(req), .disk_wr_mark_out(mrk), .disk_wr_mark_deleted_out(mdel), .disk_wr_strobe_out(wstb),
    .disk_wr_byte_out(wbyte), .head_load_out(hl), .busy_out(busy));
  fsts_drive drv (.clk_in(clk), .rst_b_in(rst_b), .id_en_in(id_en), .id_in(disk_set), .index_out(idx),
    .id_valid_out(idv), .id_out(id_drv), .wr_req_out(req));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  // Bit-serial CRC step, kept apart from the byte-wise form in the logic
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_step
  task automatic chk(input logic [31:0] got, exp, m);
    comparisons++;
    if (((got ^ exp) & m) !== 32'h0) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle; reads leave their expectation for the monitor
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, m);
    if (!w) q.push_back({d, m});
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask : wb
  // Launch a command with terminal count, wait for idle, check status
  task automatic run(input logic [5:0] ctl, input logic [31:0] exp, msk);
    wb(1, FSTS_ADR_ID, id_set, '0);
    wb(1, FSTS_ADR_LIMIT, 32'h0000_FF05, '0);
    wb(1, FSTS_ADR_CTRL, {26'h0, ctl}, '0);
    wr_cnt = 0;
    nz = 0;
    crc_x = CRC_INIT;
    term <= 1;
    @(posedge clk);
    term <= 0;
    while (busy !== 1'b0) @(posedge clk);
    wb(0, FSTS_ADR_STATUS, exp, msk);
  endtask : run
  task automatic tally_and_finish();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // Monitor: read answers, write channel bytes, hang limit
  always @(posedge clk) begin
    cycles++;
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      chk(rdat, e[63:32], e[31:0]);
    end
    if (wstb === 1'b1) wr_cnt++;
    if (wstb === 1'b1 && wr_cnt <= 128 && wbyte !== 8'h00) nz++;
    if (wstb === 1'b1 && wr_cnt <= 128) crc_x = crc_step(crc_x, wbyte);
    if (wstb === 1'b1 && wr_cnt > 128) chk(wbyte, wr_cnt == 129 ? crc_x[15:8] : crc_x[7:0], 32'hFF);
    if (mrk === 1'b1) mdel_seen = mdel;
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1;
    wb(0, FSTS_ADR_LIMIT, 32'h0000_0001, 32'h0000_00FF);
    wb(0, 8'h3C, 32'h0, '1);
    disk_set.r <= 8'h07;
    run(6'h01, 32'h0040_0400, 32'h01C0_0400);
    id_en <= 0;
    run(6'h05, 32'h0040_0100, 32'h01C0_0100);
    wb(0, FSTS_ADR_CTRL, 32'h0000_0004, '1);
    id_en <= 1;
    disk_set <= '0;
    crc_ok <= 0;
    run(6'h07, 32'h0040_2000, 32'h01C0_2000);
    crc_ok <= 1;
    for (int k = 0; k < 3; k++) begin
      lfsr = nxt(lfsr);
      id_set = '{lfsr[7:0], {7'h0, k == 2}, k ? 8'h05 : 8'h02, 8'h00};
      disk_set <= id_set;
      run({1'b0, k == 1, k ? CMD_WRITE_DEL : CMD_WRITE, 1'b1}, '0, 32'h01C0_0000);
      wb(0, FSTS_ADR_RESULT, {8'(lfsr[7:0] + (k == 2)), 7'h0, k != 0, k ? 8'h01 : 8'h03, 8'h00}, '1);
      chk(wr_cnt, 130, '1);
      chk(nz, 0, '1);
      chk(mdel_seen, k != 0, '1);
    end
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
